// ===== swk_cdr_regs.svh
// Constants for the selective-wake clock and data recovery block.
// Assumes a 20 MHz internal oscillator clock.
`ifndef SWK_CDR_REGS_SVH
`define SWK_CDR_REGS_SVH

`define CLK_PERIOD_NS         50
`define SAMPLE_POINT_RESET    6'h33
`define SAMPLE_POINT_W        6
`define OSC_SEL_W             2
`define LIMIT_W               8
`define BIT_TIME_MIN_NS       1000
`define BIT_TIME_MIN_CYC      ((`BIT_TIME_MIN_NS)/(`CLK_PERIOD_NS))
`define WAKE_REACT_US         100
`define WAKE_REACT_CYC       (((`WAKE_REACT_US)*1000)/(`CLK_PERIOD_NS))
`define BIAS_REACT_US         250
`define BIAS_REACT_CYC       (((`BIAS_REACT_US)*1000)/(`CLK_PERIOD_NS))
`define GLITCH2_BP            500
`define DOM2_BP               1750
`define GLITCH5_BP            250
`define DOM5_BP               875
`define BP_SCALE              10000
`define ARB_MAX_KBPS          500
`define TRX_OFF               3'h0
`define CNT_W                 13

`endif

// ===== swk_cdr_pkg.sv
// Types for the selective-wake clock and data recovery block.
// No dependencies.
package swk_cdr_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DOM  = 3'b010,
    ST_REC  = 3'b100
  } meas_state_t;

  typedef enum logic [1:0] {
    WK_IDLE = 2'b01,
    WK_WAIT = 2'b10
  } wake_state_t;

endpackage : swk_cdr_pkg

// ===== fd_glitch_filter.sv
// Flexible-data dominant pulse filter.
// Assumes rx_i synchronous to clk_i; 0 means dominant.
`timescale 1ns/1ns
`include "swk_cdr_regs.svh"

module fd_glitch_filter #(
  parameter int CNT_W = `CNT_W
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             active_i,
  input  wire logic [CNT_W-1:0] dom_min_i,
  input  wire logic             rx_i,
  output logic                  rx_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             out;
  } filt_t;

  filt_t cur;
  filt_t next_cur;

  always_comb begin
    next_cur = cur;
    if (!active_i || rx_i) begin
      next_cur.cnt = '0;
      next_cur.out = rx_i;
    end else begin
      // Short dominant pulses are swallowed until the minimum is reached
      if (cur.cnt + 1'b1 >= dom_min_i) begin
        next_cur.out = 1'b0;
      end else begin
        next_cur.cnt = cur.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cur <= '{cnt: '0, out: 1'b1};
    end else begin
      cur <= next_cur;
    end
  end

  assign rx_o = cur.out;

endmodule : fd_glitch_filter

// ===== wake_timer.sv
// Reaction timer: raises done_o a set number of cycles after start_i.
// Assumes start_i is a one-cycle pulse.
`timescale 1ns/1ns
`include "swk_cdr_regs.svh"

module wake_timer #(
  parameter int DELAY = 2
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic start_i,
  output logic      done_o
);

  localparam int W = $clog2(DELAY + 1);

  typedef struct packed {
    swk_cdr_pkg::wake_state_t st;
    logic [W-1:0]             cnt;
    logic                     done;
  } tmr_t;

  tmr_t cur;
  tmr_t next_cur;

  initial begin
    if (DELAY < 1) $error("wake_timer delay must be at least one");
  end

  always_comb begin
    next_cur      = cur;
    next_cur.done = 1'b0;
    unique case (cur.st)
      swk_cdr_pkg::WK_IDLE: begin
        if (start_i) begin
          next_cur.st  = swk_cdr_pkg::WK_WAIT;
          next_cur.cnt = '0;
        end
      end
      swk_cdr_pkg::WK_WAIT: begin
        if (cur.cnt == W'(DELAY - 1)) begin
          next_cur.done = 1'b1;
          next_cur.st   = swk_cdr_pkg::WK_IDLE;
        end else begin
          next_cur.cnt = cur.cnt + 1'b1;
        end
      end
      default: next_cur.st = swk_cdr_pkg::WK_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cur <= '{st: swk_cdr_pkg::WK_IDLE, cnt: '0, done: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign done_o = cur.done;

endmodule : wake_timer

// ===== selective_wake_clock_data_recovery.sv
// Clock and data recovery for the selective-wake frame decoder.
// Assumes all inputs synchronous to clk_i (internal CAN oscillator).
// Function
// [R1] Measure bits and retune clock while enabled
// [R2] Host keeps recovery on during selective wake
// [R3] Host toggles enable only with transceiver off
// [R4] Host sets off, clock, timing, then enable
// [R5] Baud change: host updates clock select, sample
// [R6] Baud or clock change: host rewrites limits
// [R7] Limit reached: discard, reload sample point
// [R8] Host disables recovery while updating registers
// [R9] Sample point default 11 0011, about 80%
// [R10] 2 Mbit/s: ignore 5%, accept 17.5%
// [R11] 5 Mbit/s: ignore 2.5%, accept 8.75%
// [R12] Tolerance only to 500 kbps, until FDF; code filters only after FDF (fdf_seen_i)
// [R13] Thresholds only with receiver select one
// [R14] Wake signalled within 100 us
// [R15] Stop: interrupt low; Sleep: regulator ramps
// [R16] Decoder handles bit times down to 1 us
// [R17] Bus bias within 250 us
// [R18] Sample point and clock select give quanta
// [R19] Recovery state held, cleared when disabled
`timescale 1ns/1ns
`include "swk_cdr_regs.svh"

module selective_wake_clock_data_recovery #(
  parameter int SP_W   = `SAMPLE_POINT_W,
  parameter int LIM_W  = `LIMIT_W,
  parameter int CNT_W  = `CNT_W,
  parameter int WAKE_CYC = `WAKE_REACT_CYC,
  parameter int BIAS_CYC = `BIAS_REACT_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             rx_i,
  input  wire logic             recovery_enable_i,
  input  wire logic [1:0]       osc_clock_select_i,
  input  wire logic [SP_W-1:0]  sample_point_reg_i,
  input  wire logic [LIM_W-1:0] limit_low_i,
  input  wire logic [LIM_W-1:0] limit_high_i,
  input  wire logic             fd_enable_i,
  input  wire logic             flexible_data_glitch_filter_i,
  input  wire logic             frame_receiver_select_i,
  input  wire logic             fdf_seen_i,
  input  wire logic             arb_slow_i,
  input  wire logic             wake_event_i,
  input  wire logic             stop_mode_i,
  input  wire logic             sleep_mode_i,
  input  wire logic             bias_request_i,
  input  wire logic [2:0]       trx_mode_i,
  output logic [LIM_W-1:0]      bit_quanta_o,
  output logic                  limit_reload_o,
  output logic                  sample_tick_o,
  output logic                  rx_filtered_o,
  output logic                  interrupt_pin_low_o,
  output logic                  regulator_ramp_o,
  output logic                  bus_bias_o,
  output logic                  config_ok_o
);

  initial begin
    if (SP_W != 6) $error("sample point width must be 6");
    if (LIM_W < SP_W + 2) $error("limit width too small");
    if (CNT_W < 8) $error("counter width too small");
    if (CNT_W < LIM_W + 1) $error("counter cannot hold two bit times");
    if (WAKE_CYC < 1 || BIAS_CYC < 1) $error("reaction times too short");
  end

  localparam int BIT_MIN = `BIT_TIME_MIN_CYC;

  typedef struct packed {
    swk_cdr_pkg::meas_state_t st;
    logic [LIM_W-1:0]         quanta;
    logic [LIM_W-1:0]         qcnt;
    logic [CNT_W-1:0]         meas;
    logic                     reload;
    logic                     tick;
    logic                     irq_n;
    logic                     ramp;
    logic                     bias;
  } core_t;

  core_t cur;
  core_t next_cur;

  logic             fd_active;
  logic [CNT_W-1:0] dom_min;
  logic [CNT_W-1:0] glitch_max;
  logic             rx_f;
  logic             wake_done;
  logic             bias_done;
  logic [LIM_W-1:0] start_quanta;
  logic [CNT_W-1:0] arb_bit;
  logic [CNT_W-1:0] meas_q;

  // Nominal quanta per bit: sample point scaled by the clock select
  always_comb begin
    start_quanta = LIM_W'({2'b00, sample_point_reg_i} << osc_clock_select_i); // R18
  end

  // Arbitration bit in clock cycles derived from the quanta count
  assign arb_bit = CNT_W'(cur.quanta);

  // Widest pulse that is always swallowed, per filter setting
  always_comb begin
    if (flexible_data_glitch_filter_i) begin
      glitch_max = CNT_W'((32'(arb_bit) * `GLITCH5_BP) / `BP_SCALE); // R11
    end else begin
      glitch_max = CNT_W'((32'(arb_bit) * `GLITCH2_BP) / `BP_SCALE); // R10
    end
  end

  // Dominant acceptance minimum as a fraction of the arbitration bit
  always_comb begin
    if (flexible_data_glitch_filter_i) begin
      dom_min = CNT_W'((32'(arb_bit) * `DOM5_BP) / `BP_SCALE); // R11
    end else begin
      dom_min = CNT_W'((32'(arb_bit) * `DOM2_BP) / `BP_SCALE); // R10
    end
    // Never accept a pulse that lies inside the ignore band
    if (dom_min <= glitch_max) begin
      dom_min = glitch_max + 1'b1;
    end
  end

  // Filter only in FD mode, normal receiver, slow arbitration, after FDF
  assign fd_active = fd_enable_i && frame_receiver_select_i // R13
                     && arb_slow_i && fdf_seen_i; // R12

  fd_glitch_filter #(
    .CNT_W (CNT_W)
  ) u_filter (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .active_i  (fd_active),
    .dom_min_i (dom_min),
    .rx_i      (rx_i),
    .rx_o      (rx_f)
  );

  wake_timer #(
    .DELAY (WAKE_CYC)
  ) u_wake (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .start_i (wake_event_i), // R14
    .done_o  (wake_done)
  );

  wake_timer #(
    .DELAY (BIAS_CYC)
  ) u_bias (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .start_i (bias_request_i), // R17
    .done_o  (bias_done)
  );

  assign meas_q = cur.meas;

  always_comb begin
    next_cur        = cur;
    next_cur.reload = 1'b0;
    next_cur.tick   = 1'b0;
    // Quanta counter gives the sampling tick for the decoder
    if (cur.qcnt + 1'b1 >= cur.quanta) begin
      next_cur.qcnt = '0;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.qcnt = cur.qcnt + 1'b1;
    end
    if (!recovery_enable_i) begin
      next_cur.st     = swk_cdr_pkg::ST_IDLE; // R19
      next_cur.meas   = '0;
      next_cur.quanta = start_quanta; // R1
    end else begin
      unique case (cur.st)
        swk_cdr_pkg::ST_IDLE: begin
          if (!rx_f) begin
            next_cur.st   = swk_cdr_pkg::ST_DOM;
            next_cur.meas = CNT_W'(1);
          end
        end
        swk_cdr_pkg::ST_DOM: begin
          if (rx_f) begin
            next_cur.st = swk_cdr_pkg::ST_REC;
            // Single-bit pulse not shorter than the minimum bit time
            if (meas_q >= CNT_W'(BIT_MIN) // R16
                && meas_q < CNT_W'(2 * cur.quanta)) begin
              if (meas_q > CNT_W'(cur.quanta)) begin
                next_cur.quanta = cur.quanta + 1'b1; // R1
              end else if (meas_q < CNT_W'(cur.quanta)) begin
                next_cur.quanta = cur.quanta - 1'b1; // R1
              end
            end
            next_cur.meas = '0;
          end else if (meas_q != '1) begin
            next_cur.meas = meas_q + 1'b1;
          end
        end
        swk_cdr_pkg::ST_REC: begin
          if (!rx_f) begin
            next_cur.st   = swk_cdr_pkg::ST_DOM;
            next_cur.meas = CNT_W'(1);
          end
        end
        default: next_cur.st = swk_cdr_pkg::ST_IDLE;
      endcase
      if (next_cur.quanta <= limit_low_i
          || next_cur.quanta >= limit_high_i) begin
        next_cur.quanta = start_quanta; // R7
        next_cur.st     = swk_cdr_pkg::ST_IDLE;
        next_cur.meas   = '0;
        next_cur.reload = 1'b1;
      end
    end
    // Wake indication: interrupt in Stop, regulator ramp from Sleep
    if (wake_done && stop_mode_i) begin
      next_cur.irq_n = 1'b0; // R15
    end else if (!stop_mode_i) begin
      next_cur.irq_n = 1'b1;
    end
    if (wake_done && sleep_mode_i) begin
      next_cur.ramp = 1'b1; // R15
    end else if (!sleep_mode_i && !cur.ramp) begin
      next_cur.ramp = 1'b0;
    end
    if (bias_done) begin
      next_cur.bias = 1'b1; // R17
    end else if (!bias_request_i && trx_mode_i == `TRX_OFF) begin
      next_cur.bias = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cur <= '{st: swk_cdr_pkg::ST_IDLE,
               quanta: LIM_W'(`SAMPLE_POINT_RESET), // R9
               qcnt: '0, meas: '0, reload: 1'b0, tick: 1'b0,
               irq_n: 1'b1, ramp: 1'b0, bias: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign bit_quanta_o        = cur.quanta;
  assign limit_reload_o      = cur.reload;
  assign sample_tick_o       = cur.tick;
  assign rx_filtered_o       = rx_f;
  assign interrupt_pin_low_o = cur.irq_n;
  assign regulator_ramp_o    = cur.ramp;
  assign bus_bias_o          = cur.bias;
  // Advisory: recovery should only be toggled with transceiver off
  assign config_ok_o         = (trx_mode_i == `TRX_OFF); // R3

endmodule : selective_wake_clock_data_recovery

// ===== swk_bus_node.sv
// Bus node model: drives one dominant pulse of a given length.
// Assumes go_i is a one-cycle pulse; bus is recessive when idle.
`timescale 1ns/1ns
module swk_bus_node (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] len_i,
  output logic            rx_o,
  output logic            busy_o
);
  logic [7:0] left;
  initial left = 8'h00;
  assign rx_o   = (left == 8'h00);
  assign busy_o = (left != 8'h00);
  always @(posedge clk_i) begin
    if (go_i)
      left <= len_i;
    else if (left != 8'h00)
      left <= left - 8'h01;
  end
endmodule : swk_bus_node

// ===== selective_wake_clock_data_recovery_checker.sv
// Checker for wake, bias and recovery timing at the block's ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module selective_wake_clock_data_recovery_checker #(
  parameter int WAKE_CYC = 10,
  parameter int BIAS_CYC = 20
) (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       recovery_enable_i,
  input wire logic [1:0] osc_clock_select_i,
  input wire logic [5:0] sample_point_reg_i,
  input wire logic       wake_event_i,
  input wire logic       stop_mode_i,
  input wire logic       sleep_mode_i,
  input wire logic       bias_request_i,
  input wire logic [2:0] trx_mode_i,
  input wire logic [7:0] bit_quanta_o,
  input wire logic       limit_reload_o,
  input wire logic       interrupt_pin_low_o,
  input wire logic       regulator_ramp_o,
  input wire logic       bus_bias_o,
  input wire logic       config_ok_o
);
  localparam int WK = WAKE_CYC + 2;
  localparam int BK = BIAS_CYC + 2;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_cfg_ok:
  assert property (config_ok_o == (trx_mode_i == 3'h0))
    else $error("config ok wrong");
  a_wake_stop:
  assert property (wake_event_i && stop_mode_i |->
    ##[1:WK] (!interrupt_pin_low_o || !stop_mode_i))
    else $error("no wake interrupt");
  a_int_hold:
  assert property (!interrupt_pin_low_o && stop_mode_i |=>
    !interrupt_pin_low_o) else $error("interrupt released");
  a_wake_sleep:
  assert property (wake_event_i && sleep_mode_i |->
    ##[1:WK] regulator_ramp_o) else $error("no ramp");
  a_ramp_sticky:
  assert property (regulator_ramp_o |=> regulator_ramp_o)
    else $error("ramp dropped");
  a_bias_time:
  assert property (bias_request_i |->
    ##[1:BK] (bus_bias_o || trx_mode_i == 3'h0)) else $error("no bias");
  a_off_quanta:
  assert property (!recovery_enable_i && osc_clock_select_i < 2'h2 |=>
    bit_quanta_o == 8'({2'h0, $past(sample_point_reg_i)}
    << $past(osc_clock_select_i))) else $error("quanta not loaded");
  a_reload_val:
  assert property (limit_reload_o && $past(osc_clock_select_i) < 2'h2 |->
    bit_quanta_o == 8'({2'h0, $past(sample_point_reg_i)}
    << $past(osc_clock_select_i))) else $error("bad reload");
  a_reload_pulse:
  assert property (limit_reload_o |=> !limit_reload_o)
    else $error("reload not a pulse");
  a_off_noreload:
  assert property (!recovery_enable_i |=> !limit_reload_o)
    else $error("reload while off");
endmodule : selective_wake_clock_data_recovery_checker

bind selective_wake_clock_data_recovery
  selective_wake_clock_data_recovery_checker #(
    .WAKE_CYC(WAKE_CYC), .BIAS_CYC(BIAS_CYC)
  ) checker_inst (
    .clk_i(clk_i), .reset_i(reset_i),
    .recovery_enable_i(recovery_enable_i),
    .osc_clock_select_i(osc_clock_select_i),
    .sample_point_reg_i(sample_point_reg_i),
    .wake_event_i(wake_event_i), .stop_mode_i(stop_mode_i),
    .sleep_mode_i(sleep_mode_i), .bias_request_i(bias_request_i),
    .trx_mode_i(trx_mode_i), .bit_quanta_o(bit_quanta_o),
    .limit_reload_o(limit_reload_o),
    .interrupt_pin_low_o(interrupt_pin_low_o),
    .regulator_ramp_o(regulator_ramp_o), .bus_bias_o(bus_bias_o),
    .config_ok_o(config_ok_o)
  );

// ===== selective_wake_clock_data_recovery_bench.sv
// Bench: host setup tasks plus a bus node model driving rx.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ns
module selective_wake_clock_data_recovery_bench;
  logic       clk_i, reset_i, en, fd, flt, sel, fdf, slow, wk, stop, slp;
  logic       bias, go, rx, busy, rel, tick, rxf, interrupt_pin_low, ramp, bb, cok;
  logic       sr, sd;
  logic [1:0] osc;
  logic [5:0] sp;
  logic [7:0] lo, hi, len, q;
  logic [2:0] trx;
  int         errors, cmp_count, tk;

  selective_wake_clock_data_recovery #(.WAKE_CYC(10), .BIAS_CYC(20))
  selective_wake_clock_data_recovery_inst (
    .clk_i(clk_i), .reset_i(reset_i), .rx_i(rx),
    .recovery_enable_i(en), .osc_clock_select_i(osc),
    .sample_point_reg_i(sp), .limit_low_i(lo), .limit_high_i(hi),
    .fd_enable_i(fd), .flexible_data_glitch_filter_i(flt),
    .frame_receiver_select_i(sel), .fdf_seen_i(fdf), .arb_slow_i(slow),
    .wake_event_i(wk), .stop_mode_i(stop), .sleep_mode_i(slp),
    .bias_request_i(bias), .trx_mode_i(trx), .bit_quanta_o(q),
    .limit_reload_o(rel), .sample_tick_o(tick), .rx_filtered_o(rxf),
    .interrupt_pin_low_o(interrupt_pin_low), .regulator_ramp_o(ramp),
    .bus_bias_o(bb), .config_ok_o(cok));

  swk_bus_node swk_bus_node_inst (.clk_i(clk_i), .go_i(go),
    .len_i(len), .rx_o(rx), .busy_o(busy));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // One dominant pulse; notes any reload and any filtered dominant
  task automatic send(input logic [7:0] n);
    @(posedge clk_i);
    len <= n;
    go  <= 1'b1;
    sr  = 1'b0;
    sd  = 1'b0;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (n + 12) begin
      @(negedge clk_i);
      if (rel === 1'b1) sr = 1'b1;
      if (rxf === 1'b0) sd = 1'b1;
    end
    @(posedge clk_i);
  endtask : send

  task automatic fcase(input logic f, s, input logic [7:0] n);
    @(posedge clk_i);
    flt <= f;
    sel <= s;
    send(n);
  endtask : fcase

  task automatic end_sim;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    end_sim();
  end

  initial begin
    {en, fd, flt, sel, fdf, wk, stop, slp, bias, go} = '0;
    reset_i = 1'b1;
    slow = 1'b1;
    {osc, len, trx} = '0;
    sp = 6'h33;
    lo = 8'h10;
    hi = 8'h60;
    cyc(5);
    reset_i <= 1'b0;
    cyc(3);
    chk(q, 8'h33);
    chk(interrupt_pin_low, 1'b1);
    chk(cok, 1'b1);
    tk = 0;
    repeat (102) begin
      @(negedge clk_i);
      if (tick === 1'b1) tk++;
    end
    @(posedge clk_i);
    chk(8'(tk), 8'h02);
    osc <= 2'h1;
    cyc(3);
    chk(q, 8'h66);
    osc <= 2'h0;
    send(8'd40);
    chk(q, 8'h33);
    en <= 1'b1;
    send(8'd40);
    chk(q, 8'h32);
    send(8'd60);
    chk(q, 8'h33);
    send(8'd19);
    chk(q, 8'h33);
    send(8'd20);
    chk(q, 8'h32);
    en <= 1'b0;
    lo <= 8'h32;
    cyc(3);
    en <= 1'b1;
    send(8'd40);
    chk(sr, 1'b1);
    chk(q, 8'h33);
    en <= 1'b0;
    fd <= 1'b1;
    fdf <= 1'b1;
    fcase(1'b0, 1'b1, 8'd6);
    chk(sd, 1'b0);
    fcase(1'b0, 1'b1, 8'd20);
    chk(sd, 1'b1);
    fcase(1'b1, 1'b1, 8'd3);
    chk(sd, 1'b0);
    fcase(1'b1, 1'b1, 8'd20);
    chk(sd, 1'b1);
    fcase(1'b1, 1'b0, 8'd3);
    chk(sd, 1'b1);
    fdf <= 1'b0;
    fcase(1'b1, 1'b1, 8'd3);
    chk(sd, 1'b1);
    trx <= 3'h1;
    stop <= 1'b1;
    cyc(1);
    chk(cok, 1'b0);
    wk <= 1'b1;
    cyc(1);
    wk <= 1'b0;
    cyc(14);
    chk(interrupt_pin_low, 1'b0);
    stop <= 1'b0;
    slp <= 1'b1;
    cyc(3);
    chk(interrupt_pin_low, 1'b1);
    wk <= 1'b1;
    cyc(1);
    wk <= 1'b0;
    cyc(14);
    chk(ramp, 1'b1);
    bias <= 1'b1;
    cyc(1);
    bias <= 1'b0;
    cyc(24);
    chk(bb, 1'b1);
    end_sim();
  end
endmodule : selective_wake_clock_data_recovery_bench
